// ==== logic/timer_unit.sv ====
// Timer subsystem: prescaler, three reload timers and watchdog
module timer_unit
	import timer_unit_pkg::*;
#(
	parameter int WDT_GAP = WDT_SECOND_GAP
) (
	// Clock and reset
	input  wire logic       CLK_IN,
	input  wire logic       RSTN_IN,
	// Timing strobes
	input  wire logic       INSTR_TICK_IN,
	input  wire logic       OSC_TICK_IN,
	input  wire logic       CLK_MODE_DIV_IN,
	// CPU transfer port
	input  wire logic       CMD_VALID_IN,
	input  wire timer_cmd_e CMD_CODE_IN,
	input  wire logic [3:0] ACC_IN,
	input  wire logic [3:0] REGB_IN,
	input  wire logic [1:0] ROM_HIGH_IN,
	output logic      [3:0] ACC_OUT,
	output logic      [3:0] REGB_OUT,
	output logic            READ_VALID_OUT,
	output logic            SKIP_OUT,
	// Interrupt handshake
	input  wire logic [2:0] INT_TAKEN_IN,
	output logic      [2:0] REQUEST_FLAGS_OUT,
	// Low-power entry
	input  wire logic       RETAIN_ENTER_IN,
	// Pins
	input  wire logic       PORT_DATA_IN,
	output logic            PORT_TIMER_PIN_OUT,
	output logic            RESET_PIN_OUT,
	output logic            RESET_PIN_OE_OUT,
	// Watchdog status
	output logic            WDT_ARMED_OUT,
	output logic            WDT_FIRST_OUT,
	output logic            WDT_SECOND_OUT
);

	// Control registers
	logic [3:0] prescaler_timer1_control;
	logic [3:0] timer2_control;
	logic [3:0] timer3_control;
	logic [1:0] timer1_upper_bits_store;

	// Reload registers
	logic [9:0] timer1_reload;
	logic [7:0] timer2_reload;
	logic [7:0] high_interval_reload;
	logic [7:0] low_interval_reload;

	// Prescaler and oscillator divider
	logic [2:0] pre_count;
	logic       prescaled_clock;
	logic       osc_half;

	// Timer 3 reload phase and pin toggle
	logic       t3_use_high;
	logic       t2_pin_level;
	logic [2:0] request_flags;

	// Counter outputs
	logic [9:0] t1_count;
	logic [7:0] t2_count;
	logic [7:0] t3_count;
	logic       t1_under;
	logic       t2_under;
	logic       t3_under;
	logic       wdt_under;
	logic       wdt_armed;
	logic       wdt_first;
	logic       wdt_second;

	// Command decode
	wire cmd_t1_load   = CMD_VALID_IN && (CMD_CODE_IN == CMD_T1_LOAD);
	wire cmd_t2_load   = CMD_VALID_IN && (CMD_CODE_IN == CMD_T2_LOAD);
	wire cmd_t2_reload = CMD_VALID_IN && (CMD_CODE_IN == CMD_T2_RELOAD_LOAD);
	wire cmd_t3_load   = CMD_VALID_IN && (CMD_CODE_IN == CMD_T3_LOAD);
	wire cmd_t3_high   = CMD_VALID_IN && (CMD_CODE_IN == CMD_T3_HIGH_LOAD);
	wire cmd_kick      = CMD_VALID_IN && (CMD_CODE_IN == CMD_WDT_KICK);
	wire cmd_ctrl3_wr  = CMD_VALID_IN && (CMD_CODE_IN == CMD_CTRL3_WRITE);
	wire [2:0] cmd_skip = {CMD_VALID_IN && (CMD_CODE_IN == CMD_SKIP_T3),
	                       CMD_VALID_IN && (CMD_CODE_IN == CMD_SKIP_T2),
	                       CMD_VALID_IN && (CMD_CODE_IN == CMD_SKIP_T1)};

	// Run bits and ten-bit load value
	wire       pre_run  = prescaler_timer1_control[PRE_RUN_BIT];
	wire       t1_run   = prescaler_timer1_control[T1_RUN_BIT];
	wire       t2_run   = timer2_control[T2_RUN_BIT];
	wire       t3_run   = timer3_control[T3_RUN_BIT];
	wire [9:0] t1_value = {timer1_upper_bits_store, REGB_IN, ACC_IN};
	wire [7:0] ab_value = {REGB_IN, ACC_IN};

	// Prescaler terminal count by ratio bit
	wire [2:0] pre_last = prescaler_timer1_control[PRE_RATIO_BIT] ? PRE_LAST_DIV8
	                                                              : PRE_LAST_DIV4;
	wire       pre_wrap = INSTR_TICK_IN && (pre_count == pre_last);

	// Timer 1 source: prescaled clock or timer 3 underflow
	wire t1_src   = prescaler_timer1_control[T1_SRC_BIT] ? t3_under : prescaled_clock;
	wire t1_pulse = t1_run && t1_src;

	// Timer 2 source select
	wire [1:0] t2_sel = timer2_control[1:0];
	wire t2_src = (t2_sel == SRC_PRESCALED) ? prescaled_clock :
	              (t2_sel == SRC_T1_UNDER)  ? t1_under :
	              (t2_sel == SRC_INSTR)     ? INSTR_TICK_IN : wdt_under;
	wire t2_pulse = t2_run && t2_src;

	// Timer 3 source select; oscillator halved in divided clock mode
	wire [1:0] t3_sel   = timer3_control[1:0];
	wire       osc_src  = OSC_TICK_IN && (!CLK_MODE_DIV_IN || osc_half);
	wire       t3_src   = (t3_sel == SRC_PRESCALED) ? prescaled_clock :
	                      (t3_sel == SRC_T2_UNDER)  ? t2_under : osc_src;
	wire       t3_pulse = t3_run && t3_src;
	wire [7:0] t3_next  = t3_use_high ? high_interval_reload : low_interval_reload;
	wire       t3_start = cmd_ctrl3_wr && ACC_IN[T3_RUN_BIT] && !t3_run;

	// Timer 1 load goes to the counter only while stopped
	wire t1_load_counter = cmd_t1_load && !t1_run;

	// Request flags: underflow sets, ack or skip clears, set wins
	wire [2:0] unders     = {t3_under, t2_under, t1_under};
	wire [2:0] next_flags = unders | (request_flags & ~(INT_TAKEN_IN | cmd_skip));

	// Timer output pin follows the toggle or the port data
	wire next_pin = timer2_control[T2_PIN_SEL_BIT] ? t2_pin_level : PORT_DATA_IN;

	// Prescaler divider; stopping clears it and silences its output
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			pre_count       <= '0;
			prescaled_clock <= 1'b0;
		end else if (!pre_run) begin
			pre_count       <= '0;
			prescaled_clock <= 1'b0;
		end else begin
			prescaled_clock <= pre_wrap;
			if (pre_wrap)
				pre_count <= '0;
			else if (INSTR_TICK_IN)
				pre_count <= pre_count + 1'b1;
		end
	end

	// Oscillator halving phase
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN)
			osc_half <= 1'b0;
		else if (OSC_TICK_IN)
			osc_half <= !osc_half;
	end

	// Control and store registers
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			prescaler_timer1_control <= CTRL_RESET;
			timer2_control           <= CTRL_RESET;
			timer3_control           <= CTRL_RESET;
			timer1_upper_bits_store  <= STORE_RESET;
		end else if (CMD_VALID_IN) begin
			unique case (CMD_CODE_IN)
				CMD_CTRL1_WRITE: prescaler_timer1_control <= ACC_IN;
				CMD_CTRL2_WRITE: timer2_control <= ACC_IN;
				CMD_CTRL3_WRITE: timer3_control <= ACC_IN;
				CMD_STORE_WRITE: timer1_upper_bits_store <= ACC_IN[1:0];
				CMD_ROM_FETCH:   timer1_upper_bits_store <= ROM_HIGH_IN;
				CMD_T1_READ:     timer1_upper_bits_store <= t1_count[9:8];
				default: ;
			endcase
		end
	end

	// Reload registers
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			timer1_reload        <= '0;
			timer2_reload        <= '0;
			high_interval_reload <= '0;
			low_interval_reload  <= '0;
		end else begin
			if (cmd_t1_load)
				timer1_reload <= t1_value;
			if (cmd_t2_load || cmd_t2_reload)
				timer2_reload <= ab_value;
			if (cmd_t3_load)
				low_interval_reload <= ab_value;
			if (cmd_t3_high)
				high_interval_reload <= ab_value;
		end
	end

	// Timer 3 reload phase: high first after start or load
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN)
			t3_use_high <= 1'b1;
		else if (cmd_t3_load || t3_start)
			t3_use_high <= 1'b1;
		else if (t3_under)
			t3_use_high <= !t3_use_high;
	end

	// Timer 1: ten-bit down counter
	reload_down_counter #(
		.WIDTH(T1_WIDTH)
	) u_timer1 (
		.clk          (CLK_IN),
		.rst_n        (RSTN_IN),
		.load         (t1_load_counter),
		.load_value   (t1_value),
		.count_pulse  (t1_pulse),
		.reload_value (timer1_reload),
		.count        (t1_count),
		.underflow    (t1_under)
	);

	// Timer 2: eight-bit counter, holds state while stopped
	reload_down_counter #(
		.WIDTH(T8_WIDTH)
	) u_timer2 (
		.clk          (CLK_IN),
		.rst_n        (RSTN_IN),
		.load         (cmd_t2_load),
		.load_value   (ab_value),
		.count_pulse  (t2_pulse),
		.reload_value (timer2_reload),
		.count        (t2_count),
		.underflow    (t2_under)
	);

	// Timer 3: eight-bit counter with alternating reloads
	reload_down_counter #(
		.WIDTH(T8_WIDTH)
	) u_timer3 (
		.clk          (CLK_IN),
		.rst_n        (RSTN_IN),
		.load         (cmd_t3_load),
		.load_value   (ab_value),
		.count_pulse  (t3_pulse),
		.reload_value (t3_next),
		.count        (t3_count),
		.underflow    (t3_under)
	);

	// Watchdog
	watchdog_core #(
		.SECOND_GAP(WDT_GAP)
	) u_watchdog (
		.clk          (CLK_IN),
		.rst_n        (RSTN_IN),
		.instr_tick   (INSTR_TICK_IN),
		.kick         (cmd_kick),
		.retain_enter (RETAIN_ENTER_IN),
		.underflow    (wdt_under),
		.armed        (wdt_armed),
		.first_flag   (wdt_first),
		.second_flag  (wdt_second)
	);

	// Flags, pin and watchdog outputs
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			request_flags      <= '0;
			t2_pin_level       <= 1'b0;
			PORT_TIMER_PIN_OUT <= 1'b0;
			RESET_PIN_OUT      <= 1'b0;
			RESET_PIN_OE_OUT   <= 1'b0;
			WDT_ARMED_OUT      <= 1'b0;
			WDT_FIRST_OUT      <= 1'b0;
			WDT_SECOND_OUT     <= 1'b0;
		end else begin
			request_flags      <= next_flags;
			if (t2_under)
				t2_pin_level <= !t2_pin_level;
			PORT_TIMER_PIN_OUT <= next_pin;
			RESET_PIN_OUT      <= 1'b0;
			RESET_PIN_OE_OUT   <= wdt_second;
			WDT_ARMED_OUT      <= wdt_armed;
			WDT_FIRST_OUT      <= wdt_first;
			WDT_SECOND_OUT     <= wdt_second;
		end
	end

	assign REQUEST_FLAGS_OUT = request_flags;

	// Read answers, one cycle after the command
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ACC_OUT        <= '0;
			REGB_OUT       <= '0;
			READ_VALID_OUT <= 1'b0;
			SKIP_OUT       <= 1'b0;
		end else begin
			READ_VALID_OUT <= 1'b0;
			SKIP_OUT       <= |(cmd_skip & request_flags);
			if (CMD_VALID_IN) begin
				unique case (CMD_CODE_IN)
					CMD_CTRL1_READ: begin
						ACC_OUT        <= prescaler_timer1_control;
						READ_VALID_OUT <= 1'b1;
					end
					CMD_CTRL2_READ: begin
						ACC_OUT        <= timer2_control;
						READ_VALID_OUT <= 1'b1;
					end
					CMD_CTRL3_READ: begin
						ACC_OUT        <= timer3_control;
						READ_VALID_OUT <= 1'b1;
					end
					CMD_STORE_READ: begin
						ACC_OUT        <= {2'h0, timer1_upper_bits_store};
						READ_VALID_OUT <= 1'b1;
					end
					CMD_T1_READ: begin
						{REGB_OUT, ACC_OUT} <= t1_count[7:0];
						READ_VALID_OUT      <= 1'b1;
					end
					CMD_T2_READ: begin
						{REGB_OUT, ACC_OUT} <= t2_count;
						READ_VALID_OUT      <= 1'b1;
					end
					CMD_T3_READ: begin
						{REGB_OUT, ACC_OUT} <= t3_count;
						READ_VALID_OUT      <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

endmodule // timer_unit

// ==== logic/timer_unit_pkg.sv ====
package timer_unit_pkg;

	// CPU transfer commands
	typedef enum logic [4:0] {
		CMD_NOP,
		CMD_CTRL1_WRITE,
		CMD_CTRL1_READ,
		CMD_CTRL2_WRITE,
		CMD_CTRL2_READ,
		CMD_CTRL3_WRITE,
		CMD_CTRL3_READ,
		CMD_STORE_WRITE,
		CMD_STORE_READ,
		CMD_ROM_FETCH,
		CMD_T1_LOAD,
		CMD_T1_READ,
		CMD_T2_LOAD,
		CMD_T2_READ,
		CMD_T2_RELOAD_LOAD,
		CMD_T3_LOAD,
		CMD_T3_HIGH_LOAD,
		CMD_T3_READ,
		CMD_SKIP_T1,
		CMD_SKIP_T2,
		CMD_SKIP_T3,
		CMD_WDT_KICK
	} timer_cmd_e;

	// Control register bit positions
	localparam int T1_RUN_BIT      = 0;
	localparam int T1_SRC_BIT      = 1;
	localparam int PRE_RATIO_BIT   = 2;
	localparam int PRE_RUN_BIT     = 3;
	localparam int T2_PIN_SEL_BIT  = 2;
	localparam int T2_RUN_BIT      = 3;
	localparam int T3_RUN_BIT      = 3;

	// Widths and reset values
	localparam int T1_WIDTH  = 10;
	localparam int T8_WIDTH  = 8;
	localparam int WDT_WIDTH = 16;
	localparam logic [3:0] CTRL_RESET  = 4'h0;
	localparam logic [1:0] STORE_RESET = 2'h0;

	// Prescaler terminal counts (ratio minus one)
	localparam logic [2:0] PRE_LAST_DIV4 = 3'h3;
	localparam logic [2:0] PRE_LAST_DIV8 = 3'h7;

	// Source select codes
	localparam logic [1:0] SRC_PRESCALED = 2'h0;
	localparam logic [1:0] SRC_T1_UNDER  = 2'h1;
	localparam logic [1:0] SRC_INSTR     = 2'h2;
	localparam logic [1:0] SRC_WDT_UNDER = 2'h3;
	localparam logic [1:0] SRC_T2_UNDER  = 2'h1;

	// Watchdog values
	localparam logic [15:0] WDT_RESET_VALUE = 16'hFFFF;
	localparam logic [15:0] WDT_CLEAR_VALUE = 16'h0000;
	localparam logic [15:0] WDT_MARK_HIGH   = 16'hBFFF;
	localparam logic [15:0] WDT_MARK_LOW    = 16'h3FFF;
	localparam int          WDT_SECOND_GAP  = 32767;

endpackage

// ==== logic/reload_down_counter.sv ====
// Down counter with load and auto-reload on the pulse after zero
module reload_down_counter
	import timer_unit_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	input  wire logic             count_pulse,
	input  wire logic [WIDTH-1:0] reload_value,
	output logic      [WIDTH-1:0] count,
	output logic                  underflow
);

	wire             at_zero   = (count == '0);
	wire [WIDTH-1:0] count_dec = count - 1'b1;

	// Load wins over counting; zero plus a pulse reloads
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count     <= '0;
			underflow <= 1'b0;
		end else begin
			underflow <= count_pulse && at_zero && !load;
			if (load)
				count <= load_value;
			else if (count_pulse && at_zero)
				count <= reload_value;
			else if (count_pulse)
				count <= count_dec;
		end
	end

endmodule // reload_down_counter

// ==== logic/watchdog_core.sv ====
// Free-running 16-bit down counter with arming and two-stage flags
module watchdog_core
	import timer_unit_pkg::*;
#(
	parameter int SECOND_GAP = WDT_SECOND_GAP
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        instr_tick,
	input  wire logic        kick,
	input  wire logic        retain_enter,
	output logic             underflow,
	output logic             armed,
	output logic             first_flag,
	output logic             second_flag
);

	logic [15:0] count;
	logic [14:0] gap;

	wire [15:0] count_dec = count - 1'b1;
	wire        at_mark   = (count_dec == WDT_MARK_HIGH) || (count_dec == WDT_MARK_LOW);
	wire        gap_done  = (gap == 15'(SECOND_GAP - 1));

	// Counter runs from reset release; low-power entry clears it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count     <= WDT_RESET_VALUE;
			underflow <= 1'b0;
		end else if (retain_enter) begin
			count     <= WDT_CLEAR_VALUE;
			underflow <= 1'b0;
		end else begin
			underflow <= instr_tick && (count_dec == WDT_CLEAR_VALUE);
			if (instr_tick)
				count <= count_dec;
		end
	end

	// Arming and flag stages
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			armed       <= 1'b0;
			first_flag  <= 1'b0;
			second_flag <= 1'b0;
			gap         <= '0;
		end else if (retain_enter) begin
			armed       <= 1'b0;
			first_flag  <= 1'b0;
			second_flag <= 1'b0;
			gap         <= '0;
		end else begin
			if (kick)
				armed <= 1'b1;
			if (armed && instr_tick && at_mark && !first_flag) begin
				first_flag <= 1'b1;
				gap        <= '0;
			end else if (kick) begin
				first_flag <= 1'b0;
				gap        <= '0;
			end else if (first_flag && instr_tick && !second_flag) begin
				gap <= gap + 1'b1;
				if (gap_done)
					second_flag <= 1'b1;
			end
		end
	end

endmodule // watchdog_core

// ==== sim/timer_unit_checker.sv ====
// Watches the timer unit's ports for watchdog, skip and read behaviour
module timer_unit_checker
	import timer_unit_pkg::*;
#(
	parameter int WDT_GAP = WDT_SECOND_GAP
) (
	// Clock and reset
	input  wire logic       CLK_IN,
	input  wire logic       RSTN_IN,
	// Commands and events
	input  wire logic       CMD_VALID_IN,
	input  wire timer_cmd_e CMD_CODE_IN,
	input  wire logic [2:0] INT_TAKEN_IN,
	input  wire logic       RETAIN_ENTER_IN,
	// Answers and status
	input  wire logic [2:0] REQUEST_FLAGS_OUT,
	input  wire logic       READ_VALID_OUT,
	input  wire logic       SKIP_OUT,
	input  wire logic       RESET_PIN_OUT,
	input  wire logic       RESET_PIN_OE_OUT,
	input  wire logic       WDT_ARMED_OUT,
	input  wire logic       WDT_FIRST_OUT,
	input  wire logic       WDT_SECOND_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);

	// Decoded commands of interest
	wire logic kick_cmd  = CMD_VALID_IN && (CMD_CODE_IN == CMD_WDT_KICK);
	wire logic skip2_cmd = CMD_VALID_IN && (CMD_CODE_IN == CMD_SKIP_T2);
	wire logic skip_cmd  = CMD_VALID_IN && (CMD_CODE_IN inside {CMD_SKIP_T1, CMD_SKIP_T2,
		CMD_SKIP_T3});
	wire logic read_cmd  = CMD_VALID_IN && (CMD_CODE_IN inside {CMD_CTRL1_READ, CMD_CTRL2_READ,
		CMD_CTRL3_READ, CMD_STORE_READ, CMD_T1_READ, CMD_T2_READ, CMD_T3_READ});
	wire logic clear2    = INT_TAKEN_IN[1] || skip2_cmd;

	a_kick_arms: assert property (kick_cmd |-> ##[1:3] WDT_ARMED_OUT)
		else $error("kick did not arm the watchdog");
	a_arm_sticky: assert property ($fell(WDT_ARMED_OUT) |-> $past(RETAIN_ENTER_IN) ||
		$past(RETAIN_ENTER_IN, 2) || $past(RETAIN_ENTER_IN, 3))
		else $error("armed flag dropped without low-power entry");
	a_first_armed: assert property ($rose(WDT_FIRST_OUT) |-> WDT_ARMED_OUT)
		else $error("first flag set while unarmed");
	a_second_chain: assert property ($rose(WDT_SECOND_OUT) |->
		WDT_ARMED_OUT && $past(WDT_FIRST_OUT, 2))
		else $error("second flag without first flag");
	a_reset_drive: assert property ($rose(WDT_SECOND_OUT) |-> ##[0:2] RESET_PIN_OE_OUT)
		else $error("second flag did not drive the reset pin");
	a_reset_low: assert property (RESET_PIN_OE_OUT |-> !RESET_PIN_OUT)
		else $error("reset pin driven high");
	a_skip_cause: assert property (SKIP_OUT |-> $past(skip_cmd))
		else $error("skip answer without a skip command");
	a_skip_set: assert property (skip2_cmd && REQUEST_FLAGS_OUT[1] && !INT_TAKEN_IN[1]
		|=> SKIP_OUT)
		else $error("skip on a set flag gave no skip");
	a_flag_cause: assert property ($fell(REQUEST_FLAGS_OUT[1]) |->
		$past(clear2) || $past(clear2, 2))
		else $error("timer 2 flag cleared with no cause");
	a_read_answer: assert property (read_cmd |=> READ_VALID_OUT)
		else $error("read gave no answer strobe");
endmodule // timer_unit_checker

bind timer_unit timer_unit_checker #(.WDT_GAP(WDT_GAP)) chk_u (
	.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .CMD_VALID_IN(CMD_VALID_IN),
	.CMD_CODE_IN(CMD_CODE_IN), .INT_TAKEN_IN(INT_TAKEN_IN),
	.RETAIN_ENTER_IN(RETAIN_ENTER_IN), .REQUEST_FLAGS_OUT(REQUEST_FLAGS_OUT),
	.READ_VALID_OUT(READ_VALID_OUT), .SKIP_OUT(SKIP_OUT), .RESET_PIN_OUT(RESET_PIN_OUT),
	.RESET_PIN_OE_OUT(RESET_PIN_OE_OUT), .WDT_ARMED_OUT(WDT_ARMED_OUT),
	.WDT_FIRST_OUT(WDT_FIRST_OUT), .WDT_SECOND_OUT(WDT_SECOND_OUT)
);

// ==== sim/cpu_core_model.sv ====
// CPU core side: issues transfer instructions and collects their answers
module cpu_core_model
	import timer_unit_pkg::*;
(
	// Clock
	input  wire logic       clk_in,
	// Instruction side
	output logic            cmd_valid_out,
	output timer_cmd_e      cmd_code_out,
	output logic      [3:0] acc_out,
	output logic      [3:0] regb_out,
	output logic      [1:0] rom_high_out,
	// Answers
	input  wire logic [3:0] acc_in,
	input  wire logic [3:0] regb_in,
	input  wire logic       read_valid_in,
	input  wire logic       skip_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero
	initial begin
		cmd_valid_out = 1'b0;
		cmd_code_out  = CMD_NOP;
		{rom_high_out, regb_out, acc_out} = 10'h000;
	end

	// One instruction: held for one edge, answer taken one cycle later
	task automatic issue(input timer_cmd_e code, input logic [9:0] data,
		output logic [7:0] rd, output logic rv, output logic sk);
		@(posedge clk_in);
		cmd_valid_out <= 1'b1;
		cmd_code_out  <= code;
		{rom_high_out, regb_out, acc_out} <= data;
		@(posedge clk_in);
		cmd_valid_out <= 1'b0;
		cmd_code_out  <= CMD_NOP;
		{rom_high_out, regb_out, acc_out} <= ~data; // Released operands show no stale value
		#1;
		rd = {regb_in, acc_in};
		rv = read_valid_in;
		sk = skip_in;
	endtask
endmodule // cpu_core_model

// ==== sim/testbench.sv ====
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
	$display("ERROR %0t: value %h expected %h", $time, (got), (exp)); end end

module testbench
	import timer_unit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int GAP = 20; // Shortened second-flag gap
	// Stimulus and observed signals
	logic       clk = 1'b0, rstn = 1'b0, instr_tick = 1'b0, osc_tick = 1'b0;
	logic       clk_mode = 1'b0, retain = 1'b0, port_data = 1'b0;
	logic [2:0] int_taken = 3'h0;
	logic       cmd_valid, read_valid, skip, pin, rst_pin, rst_oe, armed, first, second;
	timer_cmd_e cmd_code;
	logic [3:0] acc, regb, acc_rd, regb_rd;
	logic [1:0] rom_high;
	logic [2:0] flags;
	logic [7:0] rd;
	logic       rv, sk;
	int         n_tests = 0, bad_count = 0, cycles = 0;

	always #50 clk = ~clk;

	timer_unit #(.WDT_GAP(GAP)) dut_u (
		.CLK_IN(clk), .RSTN_IN(rstn), .INSTR_TICK_IN(instr_tick), .OSC_TICK_IN(osc_tick),
		.CLK_MODE_DIV_IN(clk_mode), .CMD_VALID_IN(cmd_valid), .CMD_CODE_IN(cmd_code),
		.ACC_IN(acc), .REGB_IN(regb), .ROM_HIGH_IN(rom_high), .ACC_OUT(acc_rd),
		.REGB_OUT(regb_rd), .READ_VALID_OUT(read_valid), .SKIP_OUT(skip),
		.INT_TAKEN_IN(int_taken), .REQUEST_FLAGS_OUT(flags), .RETAIN_ENTER_IN(retain),
		.PORT_DATA_IN(port_data), .PORT_TIMER_PIN_OUT(pin), .RESET_PIN_OUT(rst_pin),
		.RESET_PIN_OE_OUT(rst_oe), .WDT_ARMED_OUT(armed), .WDT_FIRST_OUT(first),
		.WDT_SECOND_OUT(second)
	);

	cpu_core_model cpu_u (
		.clk_in(clk), .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code), .acc_out(acc),
		.regb_out(regb), .rom_high_out(rom_high), .acc_in(acc_rd), .regb_in(regb_rd),
		.read_valid_in(read_valid), .skip_in(skip)
	);

	// Shared helpers
	task automatic cmd(input timer_cmd_e c, input logic [9:0] d);
		cpu_u.issue(c, d, rd, rv, sk);
	endtask
	task automatic skp(input timer_cmd_e c, input logic e);
		cmd(c, 10'h000);
		`CHK(sk, e)
	endtask
	task automatic pulses(input bit osc, input int n);
		@(posedge clk);
		osc_tick   <= osc;
		instr_tick <= !osc;
		repeat (n - 1) @(posedge clk);
		@(posedge clk);
		osc_tick   <= 1'b0;
		instr_tick <= 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic strobe(input logic [2:0] ack, input logic lp);
		@(posedge clk);
		int_taken <= ack;
		retain    <= lp;
		@(posedge clk);
		int_taken <= 3'h0;
		retain    <= 1'b0;
	endtask
	task automatic endt(input string s);
		$display("test %s finished", s);
	endtask

	// Control and store registers: reset value and read-back
	task automatic t_regs;
		timer_cmd_e wr[4];
		timer_cmd_e rc[4];
		wr = '{CMD_CTRL1_WRITE, CMD_CTRL2_WRITE, CMD_CTRL3_WRITE, CMD_STORE_WRITE};
		rc = '{CMD_CTRL1_READ, CMD_CTRL2_READ, CMD_CTRL3_READ, CMD_STORE_READ};
		`CHK(flags, 3'h0)
		for (int i = 0; i < 4; i++) begin
			cmd(rc[i], 10'h000);
			`CHK(rd[1:0], 2'h0)
			cmd(wr[i], 10'h005);
			cmd(rc[i], 10'h000);
			`CHK(rv, 1'b1)
			`CHK(rd[1:0], 2'h1)
			if (i < 3) `CHK(rd[3:2], 2'h1)
			cmd(wr[i], 10'h000);
		end
		endt("registers");
	endtask

	// Timer 1: assembled load, load while running, prescaler ratios
	task automatic t_timer1;
		cmd(CMD_ROM_FETCH, 10'h2A5);
		cmd(CMD_T1_LOAD, 10'h005);
		cmd(CMD_STORE_WRITE, 10'h000);
		cmd(CMD_T1_READ, 10'h000); // Stopped, so the count is safe to read
		`CHK(rd, 8'h05)
		cmd(CMD_STORE_READ, 10'h000);
		`CHK(rd[1:0], 2'h2)
		cmd(CMD_STORE_WRITE, 10'h000);
		cmd(CMD_T1_LOAD, 10'h002);
		cmd(CMD_CTRL1_WRITE, 10'h009); // Prescaler by 4, timer 1 on prescaled clock
		pulses(0, 8);
		cmd(CMD_T1_LOAD, 10'h007); // Count at zero, one pulse before the underflow
		pulses(0, 4);
		cmd(CMD_CTRL1_WRITE, 10'h000);
		cmd(CMD_T1_READ, 10'h000);
		`CHK(rd, 8'h07)
		`CHK(flags[0], 1'b1)
		strobe(3'h1, 1'b0);
		skp(CMD_SKIP_T1, 1'b0);
		cmd(CMD_T1_LOAD, 10'h001);
		cmd(CMD_CTRL1_WRITE, 10'h00D); // Prescaler by 8
		pulses(0, 15);
		cmd(CMD_CTRL1_WRITE, 10'h000);
		cmd(CMD_T1_READ, 10'h000);
		`CHK(rd, 8'h00)
		`CHK(flags[0], 1'b0)
		endt("timer1");
	endtask

	// Timer 2: stop retains, reload-only load, underflow flag and skip
	task automatic t_timer2;
		cmd(CMD_T2_LOAD, 10'h003);
		cmd(CMD_CTRL2_WRITE, 10'h00A);
		pulses(0, 3);
		cmd(CMD_CTRL2_WRITE, 10'h000);
		pulses(0, 2);
		cmd(CMD_T2_READ, 10'h000);
		`CHK(rd, 8'h00)
		`CHK(flags[1], 1'b0)
		cmd(CMD_T2_RELOAD_LOAD, 10'h001);
		cmd(CMD_CTRL2_WRITE, 10'h00A);
		pulses(0, 1);
		cmd(CMD_CTRL2_WRITE, 10'h000);
		cmd(CMD_T2_READ, 10'h000);
		`CHK(rd, 8'h01)
		`CHK(flags[1], 1'b1)
		skp(CMD_SKIP_T2, 1'b1);
		skp(CMD_SKIP_T2, 1'b0);
		`CHK(flags[1], 1'b0)
		endt("timer2");
	endtask

	// Shared pin: port level, then timer 2 underflow toggles
	task automatic t_pin;
		logic p;
		cmd(CMD_CTRL2_WRITE, 10'h000);
		`CHK(pin, 1'b0)
		@(posedge clk);
		port_data <= 1'b1;
		idle(3);
		`CHK(pin, 1'b1)
		cmd(CMD_CTRL2_WRITE, 10'h00E);
		idle(2);
		p = pin;
		pulses(0, 2);
		idle(3);
		`CHK(pin, ~p)
		pulses(0, 2);
		idle(3);
		`CHK(pin, p)
		cmd(CMD_CTRL2_WRITE, 10'h000);
		endt("pin");
	endtask

	// Timer 3: alternating reloads, restart by load, halved oscillator
	task automatic t_timer3;
		cmd(CMD_T3_LOAD, 10'h002);
		cmd(CMD_T3_HIGH_LOAD, 10'h005);
		cmd(CMD_CTRL3_WRITE, 10'h00A);
		pulses(1, 3);
		skp(CMD_SKIP_T3, 1'b1);
		pulses(1, 5);
		skp(CMD_SKIP_T3, 1'b0);
		pulses(1, 1);
		skp(CMD_SKIP_T3, 1'b1);
		pulses(1, 2);
		skp(CMD_SKIP_T3, 1'b0);
		pulses(1, 1);
		skp(CMD_SKIP_T3, 1'b1);
		cmd(CMD_T3_LOAD, 10'h001);
		pulses(1, 2);
		skp(CMD_SKIP_T3, 1'b1);
		pulses(1, 5);
		skp(CMD_SKIP_T3, 1'b0);
		pulses(1, 1);
		skp(CMD_SKIP_T3, 1'b1);
		@(posedge clk);
		clk_mode <= 1'b1;
		pulses(1, 2);
		skp(CMD_SKIP_T3, 1'b0);
		pulses(1, 2);
		skp(CMD_SKIP_T3, 1'b1);
		cmd(CMD_CTRL3_WRITE, 10'h000);
		cmd(CMD_T3_READ, 10'h000);
		`CHK(rd, 8'h05)
		endt("timer3");
	endtask

	// Cascade: prescaler into timer 3, timer 3 into timer 1, timer 1 into timer 2
	task automatic t_chain;
		strobe(3'h7, 1'b0);
		cmd(CMD_T3_LOAD, 10'h000);
		cmd(CMD_T3_HIGH_LOAD, 10'h000);
		cmd(CMD_T1_LOAD, 10'h001);
		cmd(CMD_T2_LOAD, 10'h000);
		cmd(CMD_CTRL2_WRITE, 10'h009); // Timer 2 on timer 1 underflow
		cmd(CMD_CTRL3_WRITE, 10'h008); // Timer 3 on prescaled clock
		cmd(CMD_CTRL1_WRITE, 10'h00B); // Timer 1 on timer 3 underflow
		pulses(0, 4);
		idle(5);
		`CHK(flags, 3'h4)
		pulses(0, 4);
		idle(5);
		`CHK(flags, 3'h7)
		cmd(CMD_CTRL1_WRITE, 10'h000);
		cmd(CMD_CTRL2_WRITE, 10'h000);
		cmd(CMD_CTRL3_WRITE, 10'h000);
		cmd(CMD_T1_READ, 10'h000);
		`CHK(rd, 8'h01)
		strobe(3'h7, 1'b0);
		idle(2);
		`CHK(flags, 3'h0)
		endt("chain");
	endtask

	// Watchdog: arming, first and second flags, low-power clear
	task automatic t_wdt;
		`CHK(armed, 1'b0)
		strobe(3'h0, 1'b1);
		cmd(CMD_WDT_KICK, 10'h000);
		idle(2);
		`CHK(armed, 1'b1)
		pulses(0, 16384); // From 0000 through FFFF down to C000
		idle(3);
		`CHK(first, 1'b0)
		pulses(0, 1);
		idle(3);
		`CHK(first, 1'b1)
		pulses(0, GAP - 1);
		cmd(CMD_WDT_KICK, 10'h000);
		pulses(0, 2);
		idle(3);
		`CHK({first, second}, 2'h0)
		strobe(3'h0, 1'b1);
		cmd(CMD_WDT_KICK, 10'h000);
		pulses(0, 16385);
		idle(3);
		`CHK(first, 1'b1)
		pulses(0, GAP - 1);
		idle(3);
		`CHK(second, 1'b0)
		pulses(0, 1);
		idle(3);
		`CHK(second, 1'b1)
		`CHK({rst_oe, rst_pin}, 2'h2)
		strobe(3'h0, 1'b1);
		idle(3);
		`CHK({armed, first, second}, 3'h0)
		endt("watchdog");
	endtask

	// Verdict and end of run
	task automatic test_done;
		$display("compares %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			test_done();
		end
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_timer1();
		t_timer2();
		t_pin();
		t_timer3();
		t_chain();
		t_wdt();
		test_done();
	end
endmodule // testbench
